// ==== hdl/vic_top.sv ====
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "vic_regs.svh"
module vic_top #(
    parameter bit HDCP_PRESENT = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_clk_pin,
    input wire vic_pkg::vic_pin_t pin_in,
    output vic_pkg::vic_pix_t pix_out,
    output logic rx_clock_on,
    output logic rx_data_on,
    output logic hdcp_active
);
    function automatic logic addr_ok(input logic [7:0] a);
        return a == `VIC_OFS_CTRL || a == `VIC_OFS_HSTART || a == `VIC_OFS_HWIDTH ||
               a == `VIC_OFS_VSTART || a == `VIC_OFS_VLEN || a == `VIC_OFS_DELAY ||
               a == `VIC_OFS_STATUS;
    endfunction
    function automatic logic [7:0] clamp_y(input logic [7:0] b);
        return (b < `VIC_Y_MIN) ? `VIC_Y_MIN : ((b > `VIC_Y_MAX) ? `VIC_Y_MAX : b);
    endfunction
    function automatic logic [7:0] clamp_c(input logic [7:0] b);
        return (b < `VIC_C_MIN) ? `VIC_C_MIN : ((b > `VIC_C_MAX) ? `VIC_C_MAX : b);
    endfunction
    function automatic logic [11:0] sat12(input logic [11:0] v);
        return (&v) ? v : v + 1'b1;
    endfunction
    function automatic logic [10:0] sat11(input logic [10:0] v);
        return (&v) ? v : v + 1'b1;
    endfunction

    logic [31:0] ctrl_reg;
    logic [11:0] hstart_reg;
    logic [10:0] hwidth_reg;
    logic [10:0] vstart_reg;
    logic [10:0] vlen_reg;
    logic [31:0] delay_reg;
    logic [31:0] prdata_reg;
    logic [31:0] status_next;
    vic_pkg::vic_pwr_t pwr;
    vic_pkg::vic_src_t src;
    logic prog_mode;
    logic [11:0] hdelay;
    logic [10:0] vdelay;

    assign pwr = vic_pkg::vic_pwr_t'(ctrl_reg[`VIC_CTRL_PWR]);
    assign src = vic_pkg::vic_src_t'(ctrl_reg[`VIC_CTRL_SRC]);
    assign prog_mode = ctrl_reg[`VIC_CTRL_PROG];
    assign hdelay = delay_reg[`VIC_DLY_H];
    assign vdelay = delay_reg[`VIC_DLY_V];
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok(paddr);
    assign prdata = prdata_reg;

    // Control, window and delay fields
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= `VIC_CTRL_RST;
            hstart_reg <= 12'h000;
            hwidth_reg <= 11'h000;
            vstart_reg <= 11'h000;
            vlen_reg <= 11'h000;
            delay_reg <= `VIC_WIN_RST;
        end else if (psel && penable && pwrite) begin
            case (paddr)
                `VIC_OFS_CTRL: ctrl_reg <= pwdata;
                `VIC_OFS_HSTART: hstart_reg <= pwdata[11:0];
                `VIC_OFS_HWIDTH: hwidth_reg <= pwdata[10:0];
                `VIC_OFS_VSTART: vstart_reg <= pwdata[10:0];
                `VIC_OFS_VLEN: vlen_reg <= pwdata[10:0];
                `VIC_OFS_DELAY: delay_reg <= pwdata;
                default: ;
            endcase
        end
    end

    // Read data is latched in the setup phase so the access phase has no wait state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable) begin
            case (paddr)
                `VIC_OFS_CTRL: prdata_reg <= {26'h0000000, ctrl_reg[5:0]};
                `VIC_OFS_HSTART: prdata_reg <= {20'h00000, hstart_reg};
                `VIC_OFS_HWIDTH: prdata_reg <= {21'h000000, hwidth_reg};
                `VIC_OFS_VSTART: prdata_reg <= {21'h000000, vstart_reg};
                `VIC_OFS_VLEN: prdata_reg <= {21'h000000, vlen_reg};
                `VIC_OFS_DELAY: prdata_reg <= {5'h00, vdelay, 4'h0, hdelay};
                `VIC_OFS_STATUS: prdata_reg <= status_next;
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Power state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_clock_on <= 1'b0;
            rx_data_on <= 1'b0;
            hdcp_active <= 1'b0;
        end else begin
            rx_clock_on <= pwr == vic_pkg::VIC_PWR_ACTIVE || pwr == vic_pkg::VIC_PWR_STANDBY;
            rx_data_on <= pwr == vic_pkg::VIC_PWR_ACTIVE;
            // Key handling sits outside; this only enables the cipher path
            hdcp_active <= HDCP_PRESENT && ctrl_reg[`VIC_CTRL_HDCP] &&
                           pwr == vic_pkg::VIC_PWR_ACTIVE && src == vic_pkg::VIC_SRC_DVI;
        end
    end

    // Pin synchronisers
    logic [2:0] lclk_sync_reg;
    logic lclk_lvl_reg;
    vic_pkg::vic_pin_t pin_s1_reg;
    vic_pkg::vic_pin_t pin_s2_reg;
    vic_pkg::vic_pin_t pin_s3_reg;
    logic sample_en;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lclk_sync_reg <= 3'h0;
            lclk_lvl_reg <= 1'b0;
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
        end else begin
            lclk_sync_reg <= {lclk_sync_reg[1:0], link_clk_pin};
            if (lclk_sync_reg[1] == lclk_sync_reg[2]) begin
                lclk_lvl_reg <= lclk_sync_reg[2];
            end
            pin_s1_reg <= pin_in;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    // Source clock rising edge, one sample per edge
    assign sample_en = lclk_sync_reg[1] && lclk_sync_reg[2] && !lclk_lvl_reg;

    logic ev;
    logic hs_prev_reg;
    logic vs_prev_reg;
    logic de_last_reg;
    logic hs_lead;
    logic vs_lead;
    logic [7:0] byte_in;

    // Standby keeps the clock edge detector but drops DVI data
    assign ev = sample_en && (src != vic_pkg::VIC_SRC_DVI || rx_data_on);
    assign hs_lead = ev && pin_s3_reg.hs && !hs_prev_reg;
    assign vs_lead = ev && pin_s3_reg.vs && !vs_prev_reg;
    assign byte_in = pin_s3_reg.data[7:0];

    // Analog sync delays
    logic hpend_reg;
    logic vpend_reg;
    logic [11:0] hcnt_reg;
    logic [10:0] vcnt_reg;
    logic fire_h;
    logic fire_v;

    assign fire_h = (hdelay == 12'h000) ? hs_lead : (ev && hpend_reg && hcnt_reg == hdelay);
    assign fire_v = (vdelay == 11'h000) ? vs_lead : (fire_h && vpend_reg && vcnt_reg == vdelay);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hpend_reg <= 1'b0;
            vpend_reg <= 1'b0;
            hcnt_reg <= 12'h000;
            vcnt_reg <= 11'h000;
        end else begin
            if (hs_lead && hdelay != 12'h000) begin
                hpend_reg <= 1'b1;
                hcnt_reg <= 12'h001;
            end else if (ev && hpend_reg) begin
                hpend_reg <= hcnt_reg != hdelay;
                hcnt_reg <= sat12(hcnt_reg);
            end
            if (vs_lead && vdelay != 11'h000) begin
                vpend_reg <= 1'b1;
                vcnt_reg <= 11'h000;
            end else if (fire_h && vpend_reg) begin
                vpend_reg <= vcnt_reg != vdelay;
                vcnt_reg <= sat11(vcnt_reg);
            end
        end
    end

    // Embedded-code parser; FF only ever opens a timing code
    logic [7:0] b1_reg;
    logic [7:0] b2_reg;
    logic [7:0] b3_reg;
    logic act656_reg;
    logic v656_reg;
    logic field_reg;
    vic_pkg::vic_phase_t phase_reg;
    logic [7:0] cb_reg;
    logic [7:0] cr_reg;
    logic [7:0] y0_reg;
    logic code_hit;
    logic on656;

    assign on656 = ev && src == vic_pkg::VIC_SRC_656;
    assign code_hit = b3_reg == `VIC_TRS_FF && b2_reg == `VIC_TRS_ZERO &&
                      b1_reg == `VIC_TRS_ZERO;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            b1_reg <= 8'h00;
            b2_reg <= 8'h00;
            b3_reg <= 8'h00;
            act656_reg <= 1'b0;
            v656_reg <= 1'b0;
            field_reg <= 1'b0;
            phase_reg <= vic_pkg::VIC_PH_CB;
            cb_reg <= 8'h00;
            cr_reg <= 8'h00;
            y0_reg <= 8'h00;
        end else if (on656) begin
            b1_reg <= byte_in;
            b2_reg <= b1_reg;
            b3_reg <= b2_reg;
            if (code_hit) begin
                act656_reg <= !byte_in[`VIC_XY_H] && !byte_in[`VIC_XY_V];
                v656_reg <= byte_in[`VIC_XY_V];
                field_reg <= byte_in[`VIC_XY_F];
                phase_reg <= vic_pkg::VIC_PH_CB;
            end else if (byte_in == `VIC_TRS_FF) begin
                act656_reg <= 1'b0;
            end else if (act656_reg) begin
                case (phase_reg)
                    vic_pkg::VIC_PH_CB: begin
                        cb_reg <= clamp_c(byte_in);
                        phase_reg <= vic_pkg::VIC_PH_Y0;
                    end
                    vic_pkg::VIC_PH_Y0: begin
                        y0_reg <= clamp_y(byte_in);
                        phase_reg <= vic_pkg::VIC_PH_CR;
                    end
                    vic_pkg::VIC_PH_CR: begin
                        cr_reg <= clamp_c(byte_in);
                        phase_reg <= vic_pkg::VIC_PH_Y1;
                    end
                    default: phase_reg <= vic_pkg::VIC_PH_CB;
                endcase
            end
        end
    end

    // Per-source syncs, enable and pixel
    logic ihs;
    logic ivs;
    logic de_cur;
    logic pev;
    logic de_mode;
    logic [23:0] pdata;
    logic live656;

    assign live656 = act656_reg && byte_in != `VIC_TRS_FF && !code_hit;

    always_comb begin
        ihs = 1'b0;
        ivs = 1'b0;
        de_cur = 1'b0;
        pev = 1'b0;
        de_mode = 1'b0;
        pdata = pin_s3_reg.data;
        case (src)
            vic_pkg::VIC_SRC_ADC: begin
                ihs = fire_h;
                ivs = fire_v;
                pev = ev;
            end
            vic_pkg::VIC_SRC_DVI: begin
                de_mode = !prog_mode;
                de_cur = pin_s3_reg.de;
                pev = ev;
                // Hsync rebuilt from enable outside programmed mode so its jitter is ignored; vsync taken from the source
                ihs = prog_mode ? hs_lead : (ev && de_last_reg && !pin_s3_reg.de);
                ivs = vs_lead;
            end
            vic_pkg::VIC_SRC_656: begin
                de_mode = 1'b1;
                de_cur = act656_reg;
                ihs = on656 && code_hit && byte_in[`VIC_XY_H];
                ivs = on656 && code_hit && byte_in[`VIC_XY_V] && !v656_reg;
                if (phase_reg == vic_pkg::VIC_PH_CR) begin
                    pdata = {y0_reg, cb_reg, clamp_c(byte_in)};
                    pev = on656 && live656;
                end else if (phase_reg == vic_pkg::VIC_PH_Y1) begin
                    pdata = {clamp_y(byte_in), cb_reg, cr_reg};
                    pev = on656 && live656;
                end
            end
            default: ;
        endcase
    end

    // Counters and window compare
    logic [11:0] pcnt_reg;
    logic [10:0] line_reg;
    logic vfirst_reg;
    logic [10:0] dline_reg;
    logic dfirst_reg;
    logic restart_reg;
    logic de_rise;
    logic [10:0] dline_cur;
    logic dfirst_cur;
    logic [11:0] pcnt_cur;
    logic [10:0] line_cur;
    logic vfirst_cur;
    logic [11:0] hoff;
    logic [10:0] voff;
    logic active;

    assign de_rise = ev && de_cur && !de_last_reg;
    // Line index seen by the enable rise itself, so the first enabled sample is not lost
    assign dline_cur = de_rise ? (dfirst_reg ? 11'h000 : sat11(dline_reg)) : dline_reg;
    assign dfirst_cur = de_rise ? 1'b0 : dfirst_reg;
    assign pcnt_cur = (de_mode ? (de_rise || restart_reg) : ihs) ? 12'h000 : pcnt_reg;
    assign vfirst_cur = ihs ? 1'b0 : (ivs || vfirst_reg);
    assign line_cur = ihs ? ((vfirst_reg || ivs) ? 11'h000 : sat11(line_reg)) : line_reg;
    assign hoff = pcnt_cur - hstart_reg;
    assign voff = line_cur - vstart_reg;

    always_comb begin
        if (de_mode) begin
            active = de_cur && pcnt_cur < {1'b0, hwidth_reg} && dline_cur < vlen_reg &&
                     !dfirst_cur;
        end else begin
            active = !vfirst_cur && pcnt_cur >= hstart_reg && hoff < {1'b0, hwidth_reg} &&
                     line_cur >= vstart_reg && voff < vlen_reg;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hs_prev_reg <= 1'b0;
            vs_prev_reg <= 1'b0;
            de_last_reg <= 1'b0;
        end else if (ev) begin
            hs_prev_reg <= pin_s3_reg.hs;
            vs_prev_reg <= pin_s3_reg.vs;
            de_last_reg <= de_cur;
        end
    end

    // Counters saturate so over-long lines never wrap into the window
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pcnt_reg <= 12'h000;
            restart_reg <= 1'b0;
        end else if (pev) begin
            pcnt_reg <= sat12(pcnt_cur);
            restart_reg <= 1'b0;
        end else if (de_rise || (!de_mode && ihs)) begin
            restart_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            line_reg <= 11'h000;
            vfirst_reg <= 1'b1;
        end else if (ihs || ivs) begin
            line_reg <= (ivs && !ihs) ? 11'h000 : line_cur;
            vfirst_reg <= vfirst_cur;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dline_reg <= 11'h000;
            dfirst_reg <= 1'b1;
        end else if (ivs) begin
            dfirst_reg <= 1'b1;
        end else if (de_rise) begin
            dline_reg <= dline_cur;
            dfirst_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pix_out <= '0;
        end else begin
            pix_out.valid <= pev && active;
            if (pev) begin
                pix_out.data <= pdata;
            end
            pix_out.hs <= ihs;
            pix_out.vs <= ivs;
            pix_out.field <= (src == vic_pkg::VIC_SRC_656) && field_reg;
        end
    end

    assign status_next = {6'h00, rx_data_on, rx_clock_on, field_reg, vfirst_reg,
                          dline_reg, line_reg};

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    luma_clamp_a: assert property (pix_out.valid && src == vic_pkg::VIC_SRC_656 |->
        pix_out.data[23:16] >= `VIC_Y_MIN && pix_out.data[23:16] <= `VIC_Y_MAX)
        else $error("luma out of range");
    chroma_clamp_a: assert property (pix_out.valid && src == vic_pkg::VIC_SRC_656 |->
        pix_out.data[15:8] >= `VIC_C_MIN && pix_out.data[15:8] <= `VIC_C_MAX &&
        pix_out.data[7:0] >= `VIC_C_MIN && pix_out.data[7:0] <= `VIC_C_MAX)
        else $error("chroma out of range");
    standby_power_a: assert property (pwr == vic_pkg::VIC_PWR_STANDBY ##1
        pwr == vic_pkg::VIC_PWR_STANDBY |-> rx_clock_on && !rx_data_on)
        else $error("standby state wrong");
    off_power_a: assert property ($rose(pwr == vic_pkg::VIC_PWR_OFF) |=>
        !rx_clock_on && !rx_data_on)
        else $error("off state wrong");
    hdcp_gate_a: assert property (hdcp_active |-> HDCP_PRESENT && rx_data_on)
        else $error("cipher active without variant");
    line_step_a: assert property (ihs && !ivs && !vfirst_reg && !(&line_reg) |=>
        line_reg == $past(line_reg) + 11'h001)
        else $error("line counter not stepped");
    origin_a: assert property (ihs && (vfirst_reg || ivs) |=>
        line_reg == 11'h000 && !vfirst_reg)
        else $error("origin not at first hsync");
    valid_window_a: assert property (pix_out.valid |-> $past(active) && $past(pev))
        else $error("inactive sample passed");
    hdelay_a: assert property (src == vic_pkg::VIC_SRC_ADC && hs_lead && hdelay != 12'h000
        |-> !fire_h)
        else $error("delayed hsync fired early");
    sync_agree_a: assert property (sample_en |=> !sample_en ##0 lclk_lvl_reg)
        else $error("edge detect broken");
endmodule

// ==== hdl/vic_regs.svh ====
`ifndef VIC_REGS_SVH
`define VIC_REGS_SVH
`define VIC_OFS_CTRL 8'h00
`define VIC_OFS_HSTART 8'h04
`define VIC_OFS_HWIDTH 8'h08
`define VIC_OFS_VSTART 8'h0c
`define VIC_OFS_VLEN 8'h10
`define VIC_OFS_DELAY 8'h14
`define VIC_OFS_STATUS 8'h18
`define VIC_CTRL_PWR 1:0
`define VIC_CTRL_SRC 3:2
`define VIC_CTRL_PROG 4
`define VIC_CTRL_HDCP 5
`define VIC_CTRL_RST 32'h0000_0000
`define VIC_WIN_RST 32'h0000_0000
`define VIC_DLY_H 11:0
`define VIC_DLY_V 26:16
`define VIC_Y_MIN 8'h10
`define VIC_Y_MAX 8'heb
`define VIC_C_MIN 8'h10
`define VIC_C_MAX 8'hf0
`define VIC_TRS_FF 8'hff
`define VIC_TRS_ZERO 8'h00
`define VIC_XY_H 4
`define VIC_XY_V 5
`define VIC_XY_F 6
`define VIC_TMDS_MIN_MHZ 20
`define VIC_TMDS_MAX_MHZ 165
`endif

// ==== hdl/vic_pkg.sv ====
package vic_pkg;
    typedef enum logic [1:0] {VIC_PWR_OFF, VIC_PWR_STANDBY, VIC_PWR_ACTIVE} vic_pwr_t;
    typedef enum logic [1:0] {VIC_SRC_ADC, VIC_SRC_DVI, VIC_SRC_656} vic_src_t;
    typedef enum logic [1:0] {VIC_PH_CB, VIC_PH_Y0, VIC_PH_CR, VIC_PH_Y1} vic_phase_t;
    typedef struct packed {
        logic [23:0] data;
        logic hs;
        logic vs;
        logic de;
    } vic_pin_t;
    typedef struct packed {
        logic valid;
        logic [23:0] data;
        logic hs;
        logic vs;
        logic field;
    } vic_pix_t;
endpackage

// ==== tb/vic_src_model.sv ====
`timescale 1ns/1ps
module vic_src_model (
    output logic link_clk,
    output vic_pkg::vic_pin_t pin
);
    initial begin
        link_clk = 1'b0;
        pin = '0;
    end
    function automatic logic [23:0] px(input int l, input int p);
        return {8'h5a, l[7:0], p[7:0]};
    endfunction
    // Data moves at the falling edge, well away from the sampled rising edge
    task automatic sample(input logic [23:0] d, input logic hs, input logic vs, input logic de);
        pin = {d, hs, vs, de};
        #62.5 link_clk = 1'b1;
        #62.5 link_clk = 1'b0;
    endtask
    // Clock stands still between frames; undriven data drifts
    task automatic park();
        pin.data = ~pin.data;
        pin.hs = 1'b0;
        pin.de = 1'b0;
    endtask
    task automatic frame(input int lines, input int pix, input int de_lo, input int de_hi);
        sample(24'h0, 1'b0, 1'b1, 1'b0);
        for (int l = 0; l < lines; l++) begin
            for (int p = 0; p < pix; p++) begin
                sample(px(l, p), p == 0, 1'b0, p >= de_lo && p < de_hi);
            end
        end
        park();
    endtask
    task automatic b656(input logic [7:0] b);
        sample({16'h0, b}, 1'b0, 1'b0, 1'b0);
    endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`include "vic_regs.svh"
module tb;
    logic clk;
    logic reset;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic link_clk;
    vic_pkg::vic_pin_t pin_in;
    vic_pkg::vic_pix_t pix_out;
    logic rx_clock_on;
    logic rx_data_on;
    logic hdcp_active;
    int bad_count = 0;
    int total_checks = 0;
    int hs_n = 0;
    int vs_n = 0;
    logic [23:0] got_q[$];
    logic [23:0] exp_q[$];
    logic [31:0] rd;
    logic err;
    logic [7:0] seq [0:23] = '{8'hff, 8'h00, 8'h00, 8'hb0, 8'hff, 8'h00, 8'h00, 8'ha0,
        8'hff, 8'h00, 8'h00, 8'h80, 8'h05, 8'hf0, 8'hfe, 8'h01,
        8'h20, 8'h40, 8'h60, 8'h80, 8'hff, 8'h00, 8'h00, 8'hd0};

    initial clk = 1'b0;
    always #5 clk = ~clk;

    vic_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_clk_pin(link_clk), .pin_in(pin_in), .pix_out(pix_out),
        .rx_clock_on(rx_clock_on), .rx_data_on(rx_data_on), .hdcp_active(hdcp_active));
    vic_src_model src (.link_clk(link_clk), .pin(pin_in));

    always @(posedge clk) begin
        if (pix_out.valid === 1'b1) begin
            got_q.push_back(pix_out.data);
        end
        if (pix_out.hs === 1'b1) begin
            hs_n++;
        end
        if (pix_out.vs === 1'b1) begin
            vs_n++;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Output lags the pin edge by a few clocks, so let the last pixel land
    task automatic cmp_q(input string msg);
        repeat (20) @(posedge clk);
        chk(got_q.size(), exp_q.size(), msg);
        for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
            chk(got_q[i], exp_q[i], msg);
        end
        got_q.delete();
        exp_q.delete();
    endtask
    task automatic win(input int hs, input int hw, input int vs, input int vl);
        apb(1'b1, `VIC_OFS_HSTART, hs);
        apb(1'b1, `VIC_OFS_HWIDTH, hw);
        apb(1'b1, `VIC_OFS_VSTART, vs);
        apb(1'b1, `VIC_OFS_VLEN, vl);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #200000;
        bad_count++;
        stop_test();
    end

    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, `VIC_OFS_CTRL, 32'h0);
        chk(rd, `VIC_CTRL_RST, "ctrl reset");
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        chk(err, 1'b1, "unmapped error");
        apb(1'b1, `VIC_OFS_HSTART, 32'h0000_0abc);
        apb(1'b0, `VIC_OFS_HSTART, 32'h0);
        chk(rd, 32'h0000_0abc, "hstart");
        apb(1'b1, `VIC_OFS_CTRL, 32'h0000_0036);
        apb(1'b0, `VIC_OFS_CTRL, 32'h0);
        chk(rd, 32'h0000_0036, "ctrl");
        repeat (2) @(posedge clk);
        chk(hdcp_active, 1'b0, "cipher without variant");
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, `VIC_OFS_CTRL, p);
            repeat (2) @(posedge clk);
            chk(rx_clock_on, p == 1 || p == 2, "clock channel");
            chk(rx_data_on, p == 2, "data channels");
        end
        // Converter source: window offset from the origin line
        apb(1'b1, `VIC_OFS_CTRL, 32'h0);
        apb(1'b1, `VIC_OFS_DELAY, 32'h0);
        win(2, 3, 1, 1);
        hs_n = 0;
        vs_n = 0;
        src.frame(3, 8, 0, 0);
        for (int p = 2; p < 5; p++) exp_q.push_back(src.px(1, p));
        cmp_q("adc window");
        chk(hs_n, 3, "adc internal hsyncs");
        chk(vs_n, 1, "adc internal vsyncs");
        // Link source in standby passes nothing
        apb(1'b1, `VIC_OFS_CTRL, 32'h5);
        win(2, 4, 0, 1);
        src.frame(2, 10, 3, 8);
        cmp_q("standby");
        // Enable mode ignores programmed starts
        apb(1'b1, `VIC_OFS_CTRL, 32'h6);
        src.frame(2, 10, 3, 8);
        for (int p = 3; p < 7; p++) exp_q.push_back(src.px(0, p));
        cmp_q("de mode");
        // Programmed mode ignores enable
        apb(1'b1, `VIC_OFS_CTRL, 32'h16);
        win(1, 2, 0, 1);
        src.frame(2, 10, 5, 7);
        for (int p = 1; p < 3; p++) exp_q.push_back(src.px(0, p));
        cmp_q("programmed mode");
        // Embedded codes, out-of-range bytes clamped
        apb(1'b1, `VIC_OFS_CTRL, 32'h8);
        win(0, 2047, 0, 2047);
        hs_n = 0;
        vs_n = 0;
        for (int i = 0; i < 24; i++) src.b656(seq[i]);
        src.park();
        exp_q.push_back({`VIC_Y_MAX, `VIC_C_MIN, `VIC_C_MAX});
        exp_q.push_back({`VIC_Y_MIN, `VIC_C_MIN, `VIC_C_MAX});
        exp_q.push_back({8'h40, 8'h20, 8'h60});
        exp_q.push_back({8'h80, 8'h20, 8'h60});
        cmp_q("embedded stream");
        chk(hs_n, 2, "embedded hsyncs");
        chk(vs_n, 1, "embedded vsyncs");
        chk(pix_out.field, 1'b1, "embedded field");
        stop_test();
    end
endmodule
